// [logic/sfd_pkg.sv]
// Constants, states and register map of the submessage flag decoder
// Operation
// - Split kind octet, flags octet and 16-bit length before kind flags.
// - Flags bit 0 picks byte order: zero big-endian, one little-endian.
// - Kinds 0x06 acknack, 0x15 data, 0x16 data fragment, 0x08 gap.
// - Senders zero unused flags; receiver ignores those positions.
// - Acknack final indication is flags mask 0x02.
// - Acknack final zero asks the writer for a heartbeat reply.
// - Acknack body: reader id, writer id, sequence set, count.
// - Data mask 0x02 marks an inline QoS list present.
// - Data mask 0x04 is the payload-is-data indication.
// - Data mask 0x08 is the payload-is-key indication.
// - Data/key clear means no payload; one set names payload content.
// - Data with both data and key set is invalid and reported.
// - Data mask 0x10 is the non-standard-payload indication.
// - Sixteen extra-flags bits are sent as zero.
// - Inline-QoS offset counts octets from after itself to QoS element.
// - Receiver always advances by that offset, then resumes there.
// - Data fragment mask 0x02 marks an inline QoS list present.
// - Data fragment mask 0x04 zero means data payload, one key payload.
// - Data fragment mask 0x08 is the non-standard-payload indication.
// - Gap mask 0x02 adds group start and end numbers.
// - Gap mask 0x04 appends a filtered change count.
// - Gap body: ids, start, list, optional group numbers, optional count.
package sfd_pkg;
    // ----------------------------------------
    // Submessage kinds
    // ----------------------------------------
    localparam logic [7:0] KIND_ACK     = 8'h06;
    localparam logic [7:0] KIND_GAP     = 8'h08;
    localparam logic [7:0] KIND_DATA    = 8'h15;
    localparam logic [7:0] KIND_FRAG    = 8'h16;
    localparam logic [7:0] KIND_PAD     = 8'h01;
    localparam logic [7:0] KIND_INFO_TS = 8'h09;
    // ----------------------------------------
    // Flag bit positions
    // ----------------------------------------
    localparam int ENDIAN_BIT    = 0;
    localparam int ACK_FINAL_BIT = 1;
    localparam int DATA_QOS_BIT  = 1;
    localparam int DATA_D_BIT    = 2;
    localparam int DATA_K_BIT    = 3;
    localparam int DATA_N_BIT    = 4;
    localparam int FRAG_QOS_BIT  = 1;
    localparam int FRAG_K_BIT    = 2;
    localparam int FRAG_N_BIT    = 3;
    localparam int GAP_G_BIT     = 1;
    localparam int GAP_F_BIT     = 2;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SUBCNT = 12'h008;
    localparam logic [11:0] REG_ERRCNT = 12'h00C;
    localparam int          CTRL_EN_BIT = 0;
    localparam int          CTRL_HB_BIT = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h3;
    localparam int          STAT_BODY_BIT  = 16;
    localparam int          STAT_EXTRA_BIT = 17;
    // ----------------------------------------
    // Parser states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_KIND   = 4'b0000,
        ST_FLAGS  = 4'b0001,
        ST_LEN0   = 4'b0010,
        ST_LEN1   = 4'b0011,
        ST_EXTRA0 = 4'b0100,
        ST_EXTRA1 = 4'b0101,
        ST_OTIQ0  = 4'b0110,
        ST_OTIQ1  = 4'b0111,
        ST_BODY   = 4'b1000
    } sfd_state_e;
endpackage

// [logic/sfd_u16_order.sv]
// Assembly of a 16-bit field from two wire octets in the selected byte order
`timescale 1ns/1ps
`default_nettype none
module sfd_u16_order (
    input  wire logic        i_little,
    input  wire logic [7:0]  i_first,
    input  wire logic [7:0]  i_second,
    output logic      [15:0] o_value
);
    always_comb begin
        if (i_little) begin
            o_value = {i_second, i_first};
        end else begin
            o_value = {i_first, i_second};
        end
    end
endmodule
`default_nettype wire

// [logic/sfd_flag_decode.sv]
// Per-kind flag extraction from the kind and flags octets
`timescale 1ns/1ps
`default_nettype none
module sfd_flag_decode (
    input  wire logic [7:0] i_kind,
    input  wire logic [7:0] i_flags,
    output logic            o_final,
    output logic            o_inline_qos,
    output logic            o_has_data,
    output logic            o_has_key,
    output logic            o_non_std,
    output logic            o_group_info,
    output logic            o_filtered_cnt,
    output logic            o_dk_invalid
);
    logic is_ack;
    logic is_data;
    logic is_frag;
    logic is_gap;
    // Unused positions never reach any output
    always_comb begin
        is_ack  = (i_kind == sfd_pkg::KIND_ACK);
        is_data = (i_kind == sfd_pkg::KIND_DATA);
        is_frag = (i_kind == sfd_pkg::KIND_FRAG);
        is_gap  = (i_kind == sfd_pkg::KIND_GAP);
        o_final = is_ack & i_flags[sfd_pkg::ACK_FINAL_BIT];
        o_inline_qos = (is_data & i_flags[sfd_pkg::DATA_QOS_BIT])
                     | (is_frag & i_flags[sfd_pkg::FRAG_QOS_BIT]);
        o_has_data = (is_data & i_flags[sfd_pkg::DATA_D_BIT])
                   | (is_frag & ~i_flags[sfd_pkg::FRAG_K_BIT]);
        o_has_key = (is_data & i_flags[sfd_pkg::DATA_K_BIT])
                  | (is_frag & i_flags[sfd_pkg::FRAG_K_BIT]);
        o_non_std = (is_data & i_flags[sfd_pkg::DATA_N_BIT])
                  | (is_frag & i_flags[sfd_pkg::FRAG_N_BIT]);
        o_group_info   = is_gap & i_flags[sfd_pkg::GAP_G_BIT];
        o_filtered_cnt = is_gap & i_flags[sfd_pkg::GAP_F_BIT];
        o_dk_invalid = is_data & i_flags[sfd_pkg::DATA_D_BIT]
                     & i_flags[sfd_pkg::DATA_K_BIT];
    end
endmodule
`default_nettype wire

// [logic/sfd_decoder.sv]
// Submessage header parser with flag outputs, body stream and APB registers
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder #(
    parameter int CNT_W = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Octet stream from the peer
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_last,
    output logic             o_rx_ready,
    // Decoded header
    output logic      [7:0]  o_kind,
    output logic             o_little_endian,
    output logic             o_final,
    output logic             o_inline_qos,
    output logic             o_has_data,
    output logic             o_has_key,
    output logic             o_non_std,
    output logic             o_group_info,
    output logic             o_filtered_cnt,
    output logic             o_dk_invalid,
    output logic             o_in_sub,
    // Body stream
    output logic             o_body_valid,
    output logic      [7:0]  o_body_data,
    output logic             o_body_resume,
    output logic             o_sub_end,
    output logic             o_hb_req
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    sfd_pkg::sfd_state_e state_r;
    logic [1:0]       ctrl_r;
    logic [7:0]       kind_r;
    logic [7:0]       flags_r;
    logic [7:0]       octet_r;
    logic [15:0]      rem_r;
    logic             unb_r;
    logic [15:0]      otiq_r;
    logic [15:0]      pos_r;
    logic             extra_nz_r;
    logic [CNT_W-1:0] subcnt_r;
    logic [CNT_W-1:0] errcnt_r;
    logic [15:0]      len_val;
    logic [15:0]      otiq_val;
    logic             fire;
    logic             body_st;
    logic             last_byte;
    logic             is_df;
    logic             hdr_take;
    logic             wr_en;
    logic             rd_en;
    logic             dec_final;
    logic             dec_qos;
    logic             dec_data;
    logic             dec_key;
    logic             dec_nstd;
    logic             dec_group;
    logic             dec_filt;
    logic             dec_inv;
    logic             addr_ok;

    // ----------------------------------------
    // Stream handshake
    // ----------------------------------------
    assign o_rx_ready = ctrl_r[sfd_pkg::CTRL_EN_BIT];
    assign fire       = i_rx_valid & o_rx_ready;
    assign body_st    = (state_r >= sfd_pkg::ST_EXTRA0);
    assign is_df      = (kind_r == sfd_pkg::KIND_DATA) | (kind_r == sfd_pkg::KIND_FRAG);
    assign hdr_take   = fire & (state_r == sfd_pkg::ST_FLAGS);
    assign last_byte  = fire & body_st & ((~unb_r & (rem_r == 16'h0001)) | i_rx_last);

    // ----------------------------------------
    // Field assembly
    // ----------------------------------------
    sfd_u16_order u_len (
        .i_little (flags_r[sfd_pkg::ENDIAN_BIT]),
        .i_first  (octet_r),
        .i_second (i_rx_data),
        .o_value  (len_val)
    );

    sfd_u16_order u_otiq (
        .i_little (flags_r[sfd_pkg::ENDIAN_BIT]),
        .i_first  (octet_r),
        .i_second (i_rx_data),
        .o_value  (otiq_val)
    );

    sfd_flag_decode u_dec (
        .i_kind         (kind_r),
        .i_flags        (i_rx_data),
        .o_final        (dec_final),
        .o_inline_qos   (dec_qos),
        .o_has_data     (dec_data),
        .o_has_key      (dec_key),
        .o_non_std      (dec_nstd),
        .o_group_info   (dec_group),
        .o_filtered_cnt (dec_filt),
        .o_dk_invalid   (dec_inv)
    );

    // ----------------------------------------
    // Header parser
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= sfd_pkg::ST_KIND;
            kind_r  <= 8'h00;
            flags_r <= 8'h00;
            octet_r <= 8'h00;
            rem_r   <= 16'h0000;
            unb_r   <= 1'b0;
        end else if (fire) begin
            case (state_r)
                sfd_pkg::ST_KIND: begin
                    kind_r  <= i_rx_data;
                    state_r <= sfd_pkg::ST_FLAGS;
                end
                sfd_pkg::ST_FLAGS: begin
                    flags_r <= i_rx_data;
                    state_r <= i_rx_last ? sfd_pkg::ST_KIND : sfd_pkg::ST_LEN0;
                end
                sfd_pkg::ST_LEN0: begin
                    octet_r <= i_rx_data;
                    state_r <= i_rx_last ? sfd_pkg::ST_KIND : sfd_pkg::ST_LEN1;
                end
                sfd_pkg::ST_LEN1: begin
                    rem_r <= len_val;
                    unb_r <= (len_val == 16'h0000);
                    if (i_rx_last) begin
                        state_r <= sfd_pkg::ST_KIND;
                    end else if (len_val == 16'h0000 &&
                                 (kind_r == sfd_pkg::KIND_PAD ||
                                  kind_r == sfd_pkg::KIND_INFO_TS)) begin
                        state_r <= sfd_pkg::ST_KIND;
                    end else if (is_df) begin
                        state_r <= sfd_pkg::ST_EXTRA0;
                    end else begin
                        state_r <= sfd_pkg::ST_BODY;
                    end
                end
                sfd_pkg::ST_EXTRA0: begin
                    rem_r   <= rem_r - 16'h0001;
                    state_r <= last_byte ? sfd_pkg::ST_KIND : sfd_pkg::ST_EXTRA1;
                end
                sfd_pkg::ST_EXTRA1: begin
                    rem_r   <= rem_r - 16'h0001;
                    state_r <= last_byte ? sfd_pkg::ST_KIND : sfd_pkg::ST_OTIQ0;
                end
                sfd_pkg::ST_OTIQ0: begin
                    octet_r <= i_rx_data;
                    rem_r   <= rem_r - 16'h0001;
                    state_r <= last_byte ? sfd_pkg::ST_KIND : sfd_pkg::ST_OTIQ1;
                end
                sfd_pkg::ST_OTIQ1: begin
                    rem_r   <= rem_r - 16'h0001;
                    state_r <= last_byte ? sfd_pkg::ST_KIND : sfd_pkg::ST_BODY;
                end
                sfd_pkg::ST_BODY: begin
                    rem_r   <= rem_r - 16'h0001;
                    state_r <= last_byte ? sfd_pkg::ST_KIND : sfd_pkg::ST_BODY;
                end
                default: begin
                    state_r <= sfd_pkg::ST_KIND;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Inline QoS offset and skip position
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            otiq_r <= 16'h0000;
            pos_r  <= 16'h0000;
        end else if (fire && state_r == sfd_pkg::ST_OTIQ1) begin
            otiq_r <= otiq_val;
            pos_r  <= 16'h0000;
        end else if (fire && state_r == sfd_pkg::ST_BODY && pos_r != 16'hFFFF) begin
            pos_r <= pos_r + 16'h0001;
        end
    end

    // Extra flags are ignored on receive, only reported
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            extra_nz_r <= 1'b0;
        end else if (hdr_take) begin
            extra_nz_r <= 1'b0;
        end else if (fire && (state_r == sfd_pkg::ST_EXTRA0 ||
                              state_r == sfd_pkg::ST_EXTRA1) && i_rx_data != 8'h00) begin
            extra_nz_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Decoded flags, held until next header
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_kind          <= 8'h00;
            o_little_endian <= 1'b0;
            o_final         <= 1'b0;
            o_inline_qos    <= 1'b0;
            o_has_data      <= 1'b0;
            o_has_key       <= 1'b0;
            o_non_std       <= 1'b0;
            o_group_info    <= 1'b0;
            o_filtered_cnt  <= 1'b0;
            o_dk_invalid    <= 1'b0;
        end else if (hdr_take) begin
            o_kind          <= kind_r;
            o_little_endian <= i_rx_data[sfd_pkg::ENDIAN_BIT];
            o_final         <= dec_final;
            o_inline_qos    <= dec_qos;
            o_has_data      <= dec_data;
            o_has_key       <= dec_key;
            o_non_std       <= dec_nstd;
            o_group_info    <= dec_group;
            o_filtered_cnt  <= dec_filt;
            o_dk_invalid    <= dec_inv;
        end
    end

    // ----------------------------------------
    // Body stream in wire order
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_body_valid  <= 1'b0;
            o_body_data   <= 8'h00;
            o_body_resume <= 1'b0;
            o_sub_end     <= 1'b0;
            o_hb_req      <= 1'b0;
            o_in_sub      <= 1'b0;
        end else begin
            o_body_valid  <= fire & (state_r == sfd_pkg::ST_BODY);
            o_body_data   <= i_rx_data;
            o_body_resume <= fire & (state_r == sfd_pkg::ST_BODY) & is_df
                           & (pos_r == otiq_r);
            o_sub_end     <= last_byte;
            o_hb_req      <= last_byte & (o_kind == sfd_pkg::KIND_ACK) & ~o_final
                           & ctrl_r[sfd_pkg::CTRL_HB_BIT];
            o_in_sub      <= hdr_take | (o_in_sub & ~last_byte
                           & ~(fire & state_r == sfd_pkg::ST_KIND));
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign o_pready = 1'b1;
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign rd_en    = i_psel & ~i_penable & ~i_pwrite;
    assign addr_ok  = (i_paddr == sfd_pkg::REG_CTRL)   | (i_paddr == sfd_pkg::REG_STATUS)
                    | (i_paddr == sfd_pkg::REG_SUBCNT) | (i_paddr == sfd_pkg::REG_ERRCNT);
    assign o_pslverr = i_psel & i_penable & ~addr_ok;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= sfd_pkg::CTRL_RST;
        end else if (wr_en && i_paddr == sfd_pkg::REG_CTRL) begin
            ctrl_r <= i_pwdata[1:0];
        end
    end

    // Counters clear on write; a count in the same cycle leaves the counter at one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            subcnt_r <= '0;
            errcnt_r <= '0;
        end else begin
            if (hdr_take) begin
                subcnt_r <= (wr_en && i_paddr == sfd_pkg::REG_SUBCNT) ?
                            CNT_W'(1) : subcnt_r + CNT_W'(1);
            end else if (wr_en && i_paddr == sfd_pkg::REG_SUBCNT) begin
                subcnt_r <= '0;
            end
            if (hdr_take && dec_inv) begin
                errcnt_r <= (wr_en && i_paddr == sfd_pkg::REG_ERRCNT) ?
                            CNT_W'(1) : errcnt_r + CNT_W'(1);
            end else if (wr_en && i_paddr == sfd_pkg::REG_ERRCNT) begin
                errcnt_r <= '0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (i_paddr)
                sfd_pkg::REG_CTRL:   o_prdata <= {30'h0000_0000, ctrl_r};
                sfd_pkg::REG_STATUS: o_prdata <= {14'h0000, extra_nz_r, o_in_sub,
                                                  flags_r, kind_r};
                sfd_pkg::REG_SUBCNT: o_prdata <= 32'(subcnt_r);
                sfd_pkg::REG_ERRCNT: o_prdata <= 32'(errcnt_r);
                default:             o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_ENDIAN: assert property (hdr_take |=>
        o_little_endian == $past(i_rx_data[0]))
        else $error("Byte order flag not taken from bit 0");
    AST_ACK_FINAL: assert property ((hdr_take && kind_r == 8'h06) |=>
        o_final == $past(i_rx_data[1]))
        else $error("Acknack final flag wrong");
    AST_HB_REQ: assert property (o_hb_req |->
        $past(last_byte) && o_kind == 8'h06 && !o_final)
        else $error("Heartbeat request without acknack final clear");
    AST_DATA_QOS: assert property ((hdr_take && kind_r == 8'h15) |=>
        o_inline_qos == $past(i_rx_data[1]) && o_has_key == $past(i_rx_data[3]))
        else $error("Data flags wrong");
    AST_DK_INVALID: assert property (o_dk_invalid |->
        o_has_data && o_has_key && o_kind == 8'h15)
        else $error("Invalid data key report wrong");
    AST_FRAG_KEY: assert property ((hdr_take && kind_r == 8'h16) |=>
        o_has_key == $past(i_rx_data[2]) && o_has_data == !$past(i_rx_data[2]))
        else $error("Fragment key flag wrong");
    AST_GAP_GROUP: assert property ((hdr_take && kind_r == 8'h08) |=>
        o_group_info == $past(i_rx_data[1]))
        else $error("Gap group flag wrong");
    AST_GAP_FILT: assert property ((hdr_take && kind_r == 8'h08) |=>
        o_filtered_cnt == $past(i_rx_data[2]))
        else $error("Gap filtered flag wrong");
    AST_RESUME: assert property (o_body_resume |->
        o_body_valid && $past(pos_r) == otiq_r)
        else $error("Resume not at inline QoS offset");
    AST_HOLD: assert property ((o_in_sub && !hdr_take) |=>
        $stable(o_kind) && $stable(o_has_key))
        else $error("Flags changed within a submessage");

    COV_ACK_HB: cover property (o_hb_req);
    COV_DK_BAD: cover property (hdr_take && dec_inv);
    COV_RESUME: cover property (o_body_resume ##1 o_body_valid);
    COV_GAP:    cover property (o_group_info && o_filtered_cnt && o_sub_end);
endmodule
`default_nettype wire

// [tb/sfd_peer.sv]
// Remote peer model that sends submessage octets
`timescale 1ns/1ps
`default_nettype none
module sfd_peer (
    input  wire logic       i_clk,
    input  wire logic       i_ready,
    output logic            o_valid,
    output logic [7:0]      o_data,
    output logic            o_last
);
    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
        o_last  = 1'b0;
    end
    task automatic put(input logic [7:0] b, input logic l);
        o_valid <= 1'b1;
        o_data  <= b;
        o_last  <= l;
        @(posedge i_clk);
        while (i_ready !== 1'b1) @(posedge i_clk);
    endtask
    task automatic send16(input logic [15:0] v, input logic le);
        put(le ? v[7:0] : v[15:8], 1'b0);
        put(le ? v[15:8] : v[7:0], 1'b0);
    endtask
    task automatic send_sub(input logic [7:0] k, f, input logic [15:0] nb, off, ex);
        logic df;
        df = (k == sfd_pkg::KIND_DATA) || (k == sfd_pkg::KIND_FRAG);
        put(k, 1'b0);
        put(f, 1'b0);
        send16(df ? nb + 16'h0004 : nb, f[0]);
        if (df) begin
            send16(ex, f[0]);
            send16(off, f[0]);
        end
        for (int i = 0; i < nb; i++) put(8'h40 + 8'(i), i == nb - 1);
        o_valid <= 1'b0;
        o_data  <= ~o_data;
        o_last  <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// [tb/sfd_decoder_tb.sv]
// Self-checking bench of the submessage decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder_tb;
    logic        i_clk, i_rstn, psel, pen, pwr, pse, hbe;
    logic [11:0] adr;
    logic [31:0] wd, rd;
    logic [15:0] bcnt, ra, scnt, hcnt, nsub;
    logic [7:0]  bd;
    int          error_cnt, num_checks, cyc;
    wire         rdy, vld, lst, prdy, err, bv, rs, se, hb, ins;
    wire  [7:0]  dat, kd, bdt;
    wire  [8:0]  fv;
    wire  [31:0] prd;
    sfd_decoder dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(adr), .i_pwdata(wd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(err), .i_rx_valid(vld), .i_rx_data(dat), .i_rx_last(lst),
        .o_rx_ready(rdy), .o_kind(kd), .o_little_endian(fv[8]), .o_final(fv[7]),
        .o_inline_qos(fv[6]), .o_has_data(fv[5]), .o_has_key(fv[4]), .o_non_std(fv[3]),
        .o_group_info(fv[2]), .o_filtered_cnt(fv[1]), .o_dk_invalid(fv[0]), .o_in_sub(ins),
        .o_body_valid(bv), .o_body_data(bdt), .o_body_resume(rs), .o_sub_end(se),
        .o_hb_req(hb));
    sfd_peer peer_u (.i_clk(i_clk), .i_ready(rdy), .o_valid(vld), .o_data(dat), .o_last(lst));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ----------------------------------------
    // Monitor, checks and bus cycles
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (bv === 1'b1) bcnt <= bcnt + 16'h1;
        if (bv === 1'b1) bd <= bdt;
        if (rs === 1'b1) ra <= bcnt;
        if (se === 1'b1) scnt <= scnt + 16'h1;
        if (hb === 1'b1) hcnt <= hcnt + 16'h1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        adr  <= a;
        wd   <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (prdy !== 1'b1);
        rd = prd;
        pse = err;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic fc(input logic [7:0] k, f, input logic [8:0] e, m);
        logic [15:0] b0, s0, h0;
        b0 = bcnt;
        s0 = scnt;
        h0 = hcnt;
        peer_u.send_sub(k, f, 16'h2, 16'h0, 16'h0);
        repeat (3) @(posedge i_clk);
        nsub++;
        check("flags", {23'h0, fv & m}, {23'h0, e & m});
        check("kind", {24'h0, kd}, {24'h0, k});
        check("body", {16'h0, bcnt - b0}, 32'h2);
        check("end", {16'h0, scnt - s0}, 32'h1);
        check("bdata", {24'h0, bd}, 32'h41);
        check("insub", {31'h0, ins}, 32'h0);
        check("hb", {16'h0, hcnt - h0}, {31'h0, k == sfd_pkg::KIND_ACK && !f[1] && hbe});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic off_case;
        logic [15:0] b0;
        b0 = bcnt;
        peer_u.send_sub(sfd_pkg::KIND_DATA, 8'h01, 16'h6, 16'h4, 16'h1);
        repeat (3) @(posedge i_clk);
        nsub++;
        check("resume", {16'h0, ra - b0}, 32'h4);
        check("le_len", {16'h0, bcnt - b0}, 32'h6);
        check("bdata_le", {24'h0, bd}, 32'h45);
        apb(1'b0, sfd_pkg::REG_STATUS, 32'h0);
        check("extra", {31'h0, rd[sfd_pkg::STAT_EXTRA_BIT]}, 32'h1);
    endtask
    task automatic pad_case;
        logic [15:0] s0;
        s0 = scnt;
        peer_u.send_sub(sfd_pkg::KIND_PAD, 8'h00, 16'h0, 16'h0, 16'h0);
        repeat (3) @(posedge i_clk);
        nsub++;
        check("pad_end", {16'h0, scnt - s0}, 32'h0);
        check("pad_kind", {24'h0, kd}, {24'h0, sfd_pkg::KIND_PAD});
    endtask
    initial begin
        {i_rstn, psel, pen, pwr, adr, wd} = '0;
        {bcnt, ra, scnt, hcnt, nsub, cyc} = '0;
        hbe = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        apb(1'b0, sfd_pkg::REG_CTRL, 32'h0);
        check("ctrl", rd, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {31'h0, pse}, 32'h1);
        fc(sfd_pkg::KIND_ACK, 8'h02, 9'h080, 9'h180);
        fc(sfd_pkg::KIND_ACK, 8'hFD, 9'h100, 9'h180);
        fc(sfd_pkg::KIND_DATA, 8'h1F, 9'h179, 9'h179);
        fc(sfd_pkg::KIND_DATA, 8'h04, 9'h020, 9'h179);
        fc(sfd_pkg::KIND_DATA, 8'h08, 9'h010, 9'h179);
        fc(sfd_pkg::KIND_FRAG, 8'h0E, 9'h058, 9'h158);
        fc(sfd_pkg::KIND_FRAG, 8'h01, 9'h100, 9'h158);
        fc(sfd_pkg::KIND_GAP, 8'h06, 9'h006, 9'h106);
        fc(sfd_pkg::KIND_GAP, 8'hF9, 9'h100, 9'h106);
        fc(8'h30, 8'hFE, 9'h000, 9'h0FF);
        pad_case;
        fc(sfd_pkg::KIND_GAP, 8'h02, 9'h004, 9'h106);
        apb(1'b0, sfd_pkg::REG_ERRCNT, 32'h0);
        check("errcnt", rd, 32'h1);
        off_case;
        apb(1'b0, sfd_pkg::REG_SUBCNT, 32'h0);
        check("subcnt", rd, {16'h0, nsub});
        apb(1'b1, sfd_pkg::REG_CTRL, 32'h1);
        hbe = 1'b0;
        fc(sfd_pkg::KIND_ACK, 8'h00, 9'h000, 9'h180);
        apb(1'b1, sfd_pkg::REG_CTRL, 32'h0);
        check("ready", {31'h0, rdy}, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
